/* File: rtl/qpta_pkg.sv */
// shared constants and types for the priority table access block
package qpta_pkg;

  // ----------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam logic [ADDR_W-1:0] IDX_VLAN_STS  = 16'h1810;
  localparam logic [ADDR_W-1:0] IDX_TBL_CMD   = 16'h1811;
  localparam logic [ADDR_W-1:0] IDX_TBL_WDATA = 16'h1812;
  localparam logic [ADDR_W-1:0] IDX_TBL_RDATA = 16'h1813;
  localparam logic [ADDR_W-1:0] IDX_TBL_STS   = 16'h1814;
  localparam logic [ADDR_W-1:0] ADDR_VLAN_STS  = IDX_VLAN_STS << 2;
  localparam logic [ADDR_W-1:0] ADDR_TBL_CMD   = IDX_TBL_CMD << 2;
  localparam logic [ADDR_W-1:0] ADDR_TBL_WDATA = IDX_TBL_WDATA << 2;
  localparam logic [ADDR_W-1:0] ADDR_TBL_RDATA = IDX_TBL_RDATA << 2;
  localparam logic [ADDR_W-1:0] ADDR_TBL_STS   = IDX_TBL_STS << 2;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int unsigned IDX_W        = 6;
  localparam int unsigned PRIO_W       = 3;
  localparam int unsigned ENTRIES      = 64;
  localparam int unsigned CMD_RNW_BIT  = 7;
  localparam int unsigned CMD_IDX_LSB  = 0;
  localparam int unsigned PEND_BIT     = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic             RNW_RST   = 1'b0;
  localparam logic [IDX_W-1:0] IDX_RST   = 6'h00;
  localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;
  localparam logic             PEND_RST  = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    QPTA_IDLE = 3'b001,
    QPTA_RUN  = 3'b010,
    QPTA_DONE = 3'b100
  } qpta_state_t;

  typedef struct packed {
    logic             valid;
    logic [IDX_W-1:0] index;
  } qpta_lookup_req_t;

  typedef struct packed {
    logic              valid;
    logic [PRIO_W-1:0] prio;
  } qpta_lookup_rsp_t;

endpackage

/* File: rtl/qpta_top.sv */
// priority table indirect access with apb register slave
`timescale 1ns/1ps
// Functional notes
// - vlan status bit 0 follows vlan table busy, clears on its own
// - a command register write with pstrb[0] set and no access pending launches the described table access
// - command bit 7 high means read, low means write, resets low
// - command bits 5:0 pick the table entry, reset to zero
// - table maps received tos/class value to receive priority
// - write data bits 2:0 hold priority to store, upper bits zero
// - read data bits 2:0 show last fetched priority, read only
// - table contents have no reset, host must fill every entry
// - table status bit 0 high during access, self clears, resets low
module qpta_top (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic [qpta_pkg::ADDR_W-1:0]    paddr,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [31:0]                    pwdata,
  input  wire logic [3:0]                     pstrb,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           vlan_busy,
  input  wire qpta_pkg::qpta_lookup_req_t     lookup_req,
  output qpta_pkg::qpta_lookup_rsp_t          lookup_rsp
);

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [qpta_pkg::PRIO_W-1:0] prio_table [qpta_pkg::ENTRIES];
  logic                        cmd_rnw;
  logic [qpta_pkg::IDX_W-1:0]  cmd_index;
  logic [qpta_pkg::PRIO_W-1:0] wr_prio;
  logic [qpta_pkg::PRIO_W-1:0] rd_prio;
  logic                        tbl_pending;
  logic                        vlan_pending;
  qpta_pkg::qpta_state_t       state;
  qpta_pkg::qpta_state_t       next_state;

  logic                        setup_phase;
  logic                        wr_commit;
  logic                        addr_hit;
  logic [31:0]                 rd_mux;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup_phase = psel & ~penable;
  assign wr_commit   = psel & penable & pready & pwrite & addr_hit;

  always_comb begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    case (paddr)
      qpta_pkg::ADDR_VLAN_STS: begin
        rd_mux[qpta_pkg::PEND_BIT] = vlan_pending;
      end
      qpta_pkg::ADDR_TBL_CMD: begin
        rd_mux[qpta_pkg::CMD_RNW_BIT] = cmd_rnw;
        rd_mux[qpta_pkg::CMD_IDX_LSB +: qpta_pkg::IDX_W] = cmd_index;
      end
      qpta_pkg::ADDR_TBL_WDATA: begin
        rd_mux[qpta_pkg::PRIO_W-1:0] = wr_prio;
      end
      qpta_pkg::ADDR_TBL_RDATA: begin
        rd_mux[qpta_pkg::PRIO_W-1:0] = rd_prio;
      end
      qpta_pkg::ADDR_TBL_STS: begin
        rd_mux[qpta_pkg::PEND_BIT] = tbl_pending;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // one wait-free access phase: answer is prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~addr_hit;
      if (setup_phase) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // command writes during a pending access are dropped so the
  // entry and direction in use cannot change underneath it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_rnw   <= qpta_pkg::RNW_RST;
      cmd_index <= qpta_pkg::IDX_RST;
    end else if (wr_commit && pstrb[0] && !tbl_pending &&
                 paddr == qpta_pkg::ADDR_TBL_CMD) begin
      cmd_rnw   <= pwdata[qpta_pkg::CMD_RNW_BIT];
      cmd_index <= pwdata[qpta_pkg::CMD_IDX_LSB +: qpta_pkg::IDX_W];
    end
  end

  // data is held in the register, so staging it early is safe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_prio <= qpta_pkg::PRIO_RST;
    end else if (wr_commit && pstrb[0] && !tbl_pending &&
                 paddr == qpta_pkg::ADDR_TBL_WDATA) begin
      wr_prio <= pwdata[qpta_pkg::PRIO_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      qpta_pkg::QPTA_IDLE: begin
        if (wr_commit && pstrb[0] && paddr == qpta_pkg::ADDR_TBL_CMD) begin
          next_state = qpta_pkg::QPTA_RUN;
        end
      end
      qpta_pkg::QPTA_RUN: begin
        next_state = qpta_pkg::QPTA_DONE;
      end
      qpta_pkg::QPTA_DONE: begin
        next_state = qpta_pkg::QPTA_IDLE;
      end
      default: begin
        next_state = qpta_pkg::QPTA_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= qpta_pkg::QPTA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // pending is high exactly while the sequencer is away from idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_pending <= qpta_pkg::PEND_RST;
    end else begin
      tbl_pending <= (next_state != qpta_pkg::QPTA_IDLE);
    end
  end

  // read result is latched before pending drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_prio <= qpta_pkg::PRIO_RST;
    end else if (state == qpta_pkg::QPTA_RUN && cmd_rnw) begin
      rd_prio <= prio_table[cmd_index];
    end
  end

  // no reset on the array: keeps it a plain ram
  always_ff @(posedge pclk) begin
    if (state == qpta_pkg::QPTA_RUN && !cmd_rnw) begin
      prio_table[cmd_index] <= wr_prio;
    end
  end

  // ----------------------------------------------------------------
  // vlan table status mirror
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vlan_pending <= qpta_pkg::PEND_RST;
    end else begin
      vlan_pending <= vlan_busy;
    end
  end

  // ----------------------------------------------------------------
  // ingress lookup port
  // ----------------------------------------------------------------
  // a lookup racing a write to the same entry sees the old value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lookup_rsp <= '0;
    end else begin
      lookup_rsp.valid <= lookup_req.valid;
      lookup_rsp.prio  <= prio_table[lookup_req.index];
    end
  end

endmodule

/* File: tb/qpta_properties.sv */
// concurrent checks on the priority table access ports
`timescale 1ns/1ps
module qpta_chk (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic [qpta_pkg::ADDR_W-1:0]  paddr,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire qpta_pkg::qpta_lookup_req_t   lookup_req,
  input wire qpta_pkg::qpta_lookup_rsp_t   lookup_rsp
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  assign mapped = paddr inside {qpta_pkg::ADDR_VLAN_STS,
    qpta_pkg::ADDR_TBL_CMD, qpta_pkg::ADDR_TBL_WDATA,
    qpta_pkg::ADDR_TBL_RDATA, qpta_pkg::ADDR_TBL_STS};
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence rd_s(a);
    setup_s ##0 (!pwrite && paddr == a);
  endsequence
  AST_ACCESS_READY: assert property (setup_s |=> pready)
    else $error("no pready in access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_UNMAPPED_ERR: assert property (setup_s ##0 (!mapped && !pwrite)
    |=> pslverr && prdata == 32'h0) else $error("unmapped read accepted");
  AST_MAPPED_OK: assert property (setup_s ##0 mapped |=> !pslverr)
    else $error("mapped access flagged");
  AST_CMD_FIELDS: assert property (rd_s(qpta_pkg::ADDR_TBL_CMD) |=>
    prdata[31:8] == 24'h0 && !prdata[6]) else $error("command spare bits");
  AST_WDATA_FIELD: assert property (rd_s(qpta_pkg::ADDR_TBL_WDATA) |=>
    prdata[31:3] == 29'h0) else $error("write data upper bits");
  AST_RDATA_FIELD: assert property (rd_s(qpta_pkg::ADDR_TBL_RDATA) |=>
    prdata[31:3] == 29'h0) else $error("read data upper bits");
  AST_STS_FIELD: assert property (rd_s(qpta_pkg::ADDR_TBL_STS) |=>
    prdata[31:1] == 31'h0) else $error("table status upper bits");
  AST_VLAN_FIELD: assert property (rd_s(qpta_pkg::ADDR_VLAN_STS) |=>
    prdata[31:1] == 31'h0) else $error("vlan status upper bits");
  AST_LOOKUP_RSP: assert property (lookup_req.valid |=> lookup_rsp.valid)
    else $error("lookup answer missing");
endmodule
bind qpta_top qpta_chk chk_u (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .lookup_req(lookup_req), .lookup_rsp(lookup_rsp));

/* File: tb/tb_top.sv */
// self-checking bench for the priority table access block
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin \
  error_cnt++; $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        vlan_busy = 0, chk = 0, pready, pslverr;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, e32;
  logic [3:0]  pstrb = 4'hf;
  logic [2:0]  e3, tbl[64];
  logic [31:0] rq[$];
  logic [2:0]  lq[$];
  int          error_cnt = 0, samples_checked = 0, cyc = 0;
  qpta_pkg::qpta_lookup_req_t lookup_req = '0;
  qpta_pkg::qpta_lookup_rsp_t lookup_rsp;
  qpta_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vlan_busy(vlan_busy), .lookup_req(lookup_req), .lookup_rsp(lookup_rsp));
  always #2 pclk = ~pclk;
  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // apb master: psel stays up so transfers can run back to back
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic c);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    chk <= c;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
  endtask
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0, 1'b1);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
    if (psel && penable && pready && !pwrite && chk) begin
      e32 = rq.pop_front();
      `CHK("prdata", e32, prdata)
    end
    if (lookup_rsp.valid === 1'b1 && lq.size() > 0) begin
      e3 = lq.pop_front();
      `CHK("lookup_rsp", e3, lookup_rsp.prio)
    end
  end
  initial begin
    logic [31:0] d;
    logic [5:0]  k;
    void'($urandom(62791));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(qpta_pkg::ADDR_TBL_CMD, 32'h0);
    rd(qpta_pkg::ADDR_TBL_WDATA, 32'h0);
    rd(qpta_pkg::ADDR_TBL_RDATA, 32'h0);
    rd(qpta_pkg::ADDR_TBL_STS, 32'h0);
    apb(1'b1, 16'h6054, 32'hffffffff, 1'b0);
    rd(16'h6054, 32'h0);
    // upper data bits are random to show they never stick
    for (int i = 0; i < 64; i++) begin
      d = $urandom;
      tbl[i] = d[2:0];
      apb(1'b1, qpta_pkg::ADDR_TBL_WDATA, d, 1'b0);
      apb(1'b1, qpta_pkg::ADDR_TBL_CMD, {24'h0, 2'b00, 6'(i)}, 1'b0);
      apb(1'b1, qpta_pkg::ADDR_TBL_WDATA, ~d, 1'b0);
      rd(qpta_pkg::ADDR_TBL_STS, 32'h0);
      rd(qpta_pkg::ADDR_TBL_WDATA, {29'h0, tbl[i]});
    end
    for (int i = 63; i >= 0; i--) begin
      apb(1'b1, qpta_pkg::ADDR_TBL_CMD, {24'h0, 2'b10, 6'(i)}, 1'b0);
      rd(qpta_pkg::ADDR_TBL_STS, 32'h1);
      rd(qpta_pkg::ADDR_TBL_STS, 32'h0);
      rd(qpta_pkg::ADDR_TBL_RDATA, {29'h0, tbl[i]});
    end
    rd(qpta_pkg::ADDR_TBL_CMD, 32'h80);
    idle();
    repeat (16) begin
      k = 6'($urandom_range(63));
      lookup_req <= {1'b1, k};
      lq.push_back(tbl[k]);
      @(posedge pclk);
    end
    lookup_req <= '0;
    // mid-run reset: registers return to reset values
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(qpta_pkg::ADDR_TBL_CMD, 32'h0);
    rd(qpta_pkg::ADDR_TBL_RDATA, 32'h0);
    rd(qpta_pkg::ADDR_TBL_WDATA, 32'h0);
    vlan_busy <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(qpta_pkg::ADDR_VLAN_STS, 32'h1);
    vlan_busy <= 1'b0;
    idle();
    repeat (2) @(posedge pclk);
    rd(qpta_pkg::ADDR_VLAN_STS, 32'h0);
    idle();
    repeat (3) @(posedge pclk);
    print_verdict();
  end
endmodule
